// File: logic/sewa_pkg.sv
// constants and types shared by the serial eeprom write front end
package sewa_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CLK_KHZ = 50000;
  localparam int GLITCH_REJECT_NS = 50;
  // a change must stand one sample longer than the widest glitch
  localparam int GLITCH_CYC = (GLITCH_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int PROG_TIME_MS = 5;
  localparam int PROG_CYCLES = PROG_TIME_MS * CLK_KHZ;
  localparam int TIMER_W = 18;
  localparam logic [3:0] DEV_CODE = 4'ha;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_DONE = 4'h9;
  localparam logic [4:0] PAGE_BYTES = 5'h10;
  localparam logic [2:0] FILT_CNT_RST = 3'h0;
  localparam logic [TIMER_W-1:0] TIMER_RST = 18'h0;

  typedef enum logic [2:0] {
    SEWA_IDLE = 3'b000,
    SEWA_DEV = 3'b001,
    SEWA_WADDR = 3'b010,
    SEWA_DATA = 3'b011,
    SEWA_IGNORE = 3'b100
  } sewa_state_t;

  typedef struct packed {
    logic [1:0] sync;
    logic [2:0] cnt;
    logic lvl;
  } sewa_filt_t;

  typedef struct packed {
    logic [1:0] rst_s;
    logic [7:0] shift;
    logic tog;
  } sewa_link_t;

  typedef struct packed {
    logic we;
    logic [10:0] addr;
    logic [7:0] wdata;
  } sewa_mem_t;

  typedef struct packed {
    sewa_state_t state;
    logic [3:0] bitcnt;
    logic ack_pend;
    logic sda_oe;
    logic sda_lo;
    logic scl_d;
    logic sda_d;
    logic [2:0] tog_s;
    logic [1:0] wp_s;
    logic wp_seen;
    logic [2:0] blk;
    logic [7:0] addr;
    logic [15:0] valid;
    logic [15:0][7:0] pbuf;
    logic prog;
    logic [TIMER_W-1:0] timer;
    logic [4:0] widx;
    sewa_mem_t mem;
  } sewa_core_t;
endpackage

// File: logic/sewa_filter.sv
// two-flop synchroniser followed by a glitch filter for one bus pin
`timescale 1ns/1ps
`default_nettype none
module sewa_filter (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_in,
  output logic level_o
);
  sewa_pkg::sewa_filt_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.sync = {s_r.sync[0], pin_in};
    // only sync[1] is judged; sync[0] feeds nothing else
    if (s_r.sync[1] == s_r.lvl) begin
      s_nxt.cnt = sewa_pkg::FILT_CNT_RST;
    end else if (s_r.cnt == 3'(sewa_pkg::GLITCH_CYC - 1)) begin
      s_nxt.lvl = s_r.sync[1];
      s_nxt.cnt = sewa_pkg::FILT_CNT_RST;
    end else begin
      s_nxt.cnt = s_r.cnt + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '{sync: 2'h3, cnt: 3'h0, lvl: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level_o = s_r.lvl;
endmodule
`default_nettype wire

// File: logic/sewa_core.sv
// serial eeprom write front end: addressing, ack, page buffer, program cycle
`timescale 1ns/1ps
`default_nettype none
module sewa_core #(
  parameter int PROG_CYCLES = sewa_pkg::PROG_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_o,
  output logic sda_oe,
  input wire logic write_protect_in,
  output logic busy,
  output logic mem_we,
  output logic [10:0] mem_addr,
  output logic [7:0] mem_wdata
);
  sewa_pkg::sewa_link_t l_r, l_nxt;
  sewa_pkg::sewa_core_t c_r, c_nxt;
  logic scl_f;
  logic sda_f;
  logic [7:0] byte_in;
  logic tog_ev;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic counting;

  // link domain: data bit taken on each rising edge of the bus clock
  always_comb begin
    l_nxt = l_r;
    l_nxt.rst_s = {l_r.rst_s[0], rst};
    if (l_r.rst_s[1]) begin
      l_nxt.shift = 8'h00;
      l_nxt.tog = 1'b0;
    end else begin
      l_nxt.shift = {l_r.shift[6:0], sda_in};
      l_nxt.tog = ~l_r.tog;
    end
  end

  // reset reaches this domain only while the bus clock runs
  always_ff @(posedge scl_clk) begin
    l_r <= l_nxt;
  end

  sewa_filter u_scl_filt (
    .clk(clk),
    .rst(rst),
    .pin_in(scl_in),
    .level_o(scl_f)
  );

  sewa_filter u_sda_filt (
    .clk(clk),
    .rst(rst),
    .pin_in(sda_in),
    .level_o(sda_f)
  );

  // shift word is stable for a whole clock high phase after the toggle
  assign byte_in = l_r.shift;
  assign tog_ev = c_r.tog_s[2] ^ c_r.tog_s[1];
  assign scl_rise = scl_f & ~c_r.scl_d;
  assign scl_fall = ~scl_f & c_r.scl_d;
  assign start_ev = scl_f & c_r.scl_d & c_r.sda_d & ~sda_f;
  assign stop_ev = scl_f & c_r.scl_d & ~c_r.sda_d & sda_f;
  assign counting = (c_r.state == sewa_pkg::SEWA_DEV) || (c_r.state == sewa_pkg::SEWA_WADDR) ||
                    (c_r.state == sewa_pkg::SEWA_DATA) || (c_r.bitcnt == sewa_pkg::BIT_ACK);

  always_comb begin
    c_nxt = c_r;
    c_nxt.scl_d = scl_f;
    c_nxt.sda_d = sda_f;
    c_nxt.tog_s = {c_r.tog_s[1:0], l_r.tog};
    c_nxt.wp_s = {c_r.wp_s[0], write_protect_in};
    c_nxt.sda_lo = 1'b0;
    c_nxt.mem.we = 1'b0;
    if (c_r.state != sewa_pkg::SEWA_IDLE && c_r.wp_s[1]) begin
      c_nxt.wp_seen = 1'b1;
    end

    // program cycle: commit buffered bytes over the first 16 cycles while the write timer runs
    if (c_r.prog) begin
      c_nxt.timer = c_r.timer + 18'h1;
      if (c_r.widx < sewa_pkg::PAGE_BYTES) begin
        c_nxt.widx = c_r.widx + 5'h1;
        if (c_r.valid[c_r.widx[3:0]]) begin
          c_nxt.mem.we = 1'b1;
          c_nxt.mem.addr = {c_r.blk, c_r.addr[7:4], c_r.widx[3:0]};
          c_nxt.mem.wdata = c_r.pbuf[c_r.widx[3:0]];
        end
      end
      if (c_r.timer == TIMER_W_CAST(PROG_CYCLES - 1)) begin
        c_nxt.prog = 1'b0;
        c_nxt.valid = 16'h0000;
      end
    end

    if (start_ev) begin
      c_nxt.state = sewa_pkg::SEWA_DEV;
      c_nxt.bitcnt = 4'h0;
      c_nxt.ack_pend = 1'b0;
      c_nxt.sda_oe = 1'b0;
      c_nxt.wp_seen = c_r.wp_s[1];
    end else if (stop_ev) begin
      c_nxt.state = sewa_pkg::SEWA_IDLE;
      c_nxt.bitcnt = 4'h0;
      c_nxt.ack_pend = 1'b0;
      c_nxt.sda_oe = 1'b0;
      if (c_r.state == sewa_pkg::SEWA_DATA && c_r.valid != 16'h0000 && !c_r.prog) begin
        if (!c_r.wp_seen && !c_r.wp_s[1]) begin
          c_nxt.prog = 1'b1;
          c_nxt.timer = sewa_pkg::TIMER_RST;
          c_nxt.widx = 5'h00;
        end else begin
          c_nxt.valid = 16'h0000;
        end
      end
    end else begin
      if (tog_ev && counting) begin
        if (c_r.bitcnt == sewa_pkg::BIT_ACK) begin
          c_nxt.bitcnt = sewa_pkg::BIT_DONE;
        end else begin
          c_nxt.bitcnt = c_r.bitcnt + 4'h1;
        end
        if (c_r.bitcnt == 4'h7) begin
          case (c_r.state)
            sewa_pkg::SEWA_DEV: begin
              if (byte_in[7:4] == sewa_pkg::DEV_CODE && !c_r.prog) begin
                c_nxt.ack_pend = 1'b1;
                c_nxt.blk = byte_in[3:1];
                if (byte_in[0]) begin
                  // read sequences are served elsewhere, protect level is not consulted
                  c_nxt.state = sewa_pkg::SEWA_IGNORE;
                end else begin
                  c_nxt.state = sewa_pkg::SEWA_WADDR;
                end
              end else begin
                c_nxt.state = sewa_pkg::SEWA_IGNORE;
              end
            end
            sewa_pkg::SEWA_WADDR: begin
              c_nxt.addr = byte_in;
              c_nxt.ack_pend = 1'b1;
              c_nxt.valid = 16'h0000;
              c_nxt.state = sewa_pkg::SEWA_DATA;
            end
            sewa_pkg::SEWA_DATA: begin
              c_nxt.pbuf[c_r.addr[3:0]] = byte_in;
              c_nxt.valid[c_r.addr[3:0]] = 1'b1;
              c_nxt.addr = {c_r.addr[7:4], c_r.addr[3:0] + 4'h1};
              c_nxt.ack_pend = 1'b1;
            end
            default: begin
              c_nxt.state = sewa_pkg::SEWA_IGNORE;
            end
          endcase
        end
      end
      // drive changes only after the bus clock falls
      if (scl_fall) begin
        if (c_r.bitcnt == sewa_pkg::BIT_ACK && c_r.ack_pend) begin
          c_nxt.sda_oe = 1'b1;
        end else if (c_r.bitcnt == sewa_pkg::BIT_DONE) begin
          c_nxt.sda_oe = 1'b0;
          c_nxt.ack_pend = 1'b0;
          c_nxt.bitcnt = 4'h0;
        end
      end
    end
  end

  function automatic logic [sewa_pkg::TIMER_W-1:0] TIMER_W_CAST(input int v);
    TIMER_W_CAST = v[sewa_pkg::TIMER_W-1:0];
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      c_r <= '0;
      c_r.scl_d <= 1'b1;
      c_r.sda_d <= 1'b1;
      c_r.state <= sewa_pkg::SEWA_IDLE;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign sda_o = c_r.sda_lo;
  assign sda_oe = c_r.sda_oe;
  assign busy = c_r.prog;
  assign mem_we = c_r.mem.we;
  assign mem_addr = c_r.mem.addr;
  assign mem_wdata = c_r.mem.wdata;

  // scl_rise kept for observability of the filtered clock
  logic unused_rise;
  assign unused_rise = scl_rise;
endmodule
`default_nettype wire

// File: verification/sewa_chk.sv
// port assertions for the serial eeprom write front end
`timescale 1ns/1ps
`default_nettype none
module sewa_chk #(
  parameter int PROG_CYCLES = 200
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic write_protect_in,
  input wire logic busy,
  input wire logic mem_we,
  input wire logic [10:0] mem_addr
);
  int cnt_r;
  // counts busy samples so program length and commit window can be checked
  always_ff @(posedge clk) cnt_r <= (busy && !rst) ? cnt_r + 1 : 0;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ack_on;
    $rose(sda_oe);
  endsequence
  sequence s_ack_hold;
    sda_oe [*8];
  endsequence
  AST_OPEN_DRAIN: assert property (sda_o == 1'b0) else $error("data driven high");
  AST_ACK_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in) else $error("ack moved, clock high");
  AST_ACK_STANDS: assert property (s_ack_on |-> s_ack_hold) else $error("ack too short");
  AST_BUSY_LEN: assert property ($fell(busy) |-> cnt_r == PROG_CYCLES) else $error("program time");
  AST_WE_WINDOW: assert property (mem_we |-> busy && cnt_r < 17) else $error("write outside commit");
  AST_WE_ORDER: assert property (mem_we && $past(mem_we) |-> mem_addr[10:4] == $past(mem_addr[10:4])
    && mem_addr[3:0] > $past(mem_addr[3:0])) else $error("commit order");
  AST_BUSY_NO_ACK: assert property (busy |-> !sda_oe) else $error("ack while busy");
  AST_WP_NO_PROG: assert property ($rose(busy) |-> !$past(write_protect_in, 8)) else $error("protected prog");
endmodule
bind sewa_core sewa_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.clk(clk), .rst(rst), .scl_in(scl_in),
  .sda_o(sda_o), .sda_oe(sda_oe), .write_protect_in(write_protect_in), .busy(busy), .mem_we(mem_we),
  .mem_addr(mem_addr));
`default_nettype wire

// File: verification/sewa_master.sv
// two-wire bus master model; link clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module sewa_master (
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  logic tk;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
    tk = 1'b0;
    #7;
    forever #62.5 tk = ~tk;
  end
  // link flops carry no reset of their own: a burst of short clock pulses lets them take rst
  // while it stands and clear again after it is released; the pulses are too narrow to pass the filter
  task automatic prime();
    repeat (6) begin
      #15 scl = 1'b0;
      #15 scl = 1'b1;
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge tk);
  endtask
  task automatic start();
    sda_rel = 1'b1;
    scl = 1'b1;
    w(8);
    sda_rel = 1'b0;
    w(8);
    scl = 1'b0;
    w(4);
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      // data set mid low phase, held through the whole high phase
      sda_rel = b[i];
      w(4);
      scl = 1'b1;
      w(8);
      scl = 1'b0;
      w(4);
    end
    sda_rel = 1'b1;
    w(4);
    scl = 1'b1;
    w(4);
    ack = !sda;
    w(4);
    scl = 1'b0;
    w(4);
  endtask
  task automatic stop();
    sda_rel = 1'b0;
    w(4);
    scl = 1'b1;
    w(8);
    sda_rel = 1'b1;
    w(8);
  endtask
endmodule
`default_nettype wire

// File: verification/sewa_core_tb.sv
// self-checking bench for the serial eeprom write front end
`timescale 1ns/1ps
`default_nettype none
module sewa_core_tb;
  localparam int PROG = 2000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wp = 1'b0;
  logic scl, sda_rel, sda_oe, sda_o, busy, mem_we, ack;
  logic [10:0] mem_addr;
  logic [7:0] mem_wdata;
  // pull-up: low when either party pulls
  wire logic sda = sda_rel & (sda_oe ? sda_o : 1'b1);
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int q[$];
  initial forever #10 clk = ~clk;
  sewa_master m (.scl(scl), .sda_rel(sda_rel), .sda(sda));
  sewa_core #(.PROG_CYCLES(PROG)) DUT (.clk(clk), .rst(rst), .scl_clk(scl), .scl_in(scl), .sda_in(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .write_protect_in(wp), .busy(busy), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  always @(negedge clk) begin
    if (mem_we && q.size() == 0) chk(1, 0);
    else if (mem_we) chk({mem_addr, mem_wdata}, q.pop_front());
  end
  task automatic poll(input int blk, input logic exp);
    m.start();
    m.put(8'(8'ha0 | blk << 1), ack);
    chk(ack, exp);
    m.stop();
  endtask
  task automatic wr(input int blk, input int wa, input int n, input int code);
    int pb[16];
    bit v[16];
    int a;
    logic [7:0] d;
    m.start();
    m.put(8'(code << 4 | blk << 1), ack);
    chk(ack, code == 10);
    if (code == 10) begin
      m.put(8'(wa), ack);
      chk(ack, 1);
      a = wa % 16;
      for (int i = 0; i < n; i++) begin
        d = 8'($urandom);
        m.put(d, ack);
        chk(ack, 1);
        pb[a] = d;
        v[a] = 1;
        a = (a + 1) % 16;
      end
    end
    // expectations must be queued before the stop: the commit starts inside it
    for (int i = 0; i < 16; i++)
      if (v[i] && !wp) q.push_back(blk << 16 | (wa & 'hf0) << 8 | i << 8 | pb[i]);
    m.stop();
    @(negedge clk);
    chk(busy, code == 10 && n > 0 && !wp);
    if (busy) poll(blk, 1'b0);
    for (int k = 0; k < 3000 && busy; k++) @(negedge clk);
    chk(q.size(), 0);
    if (code == 10) poll(blk, 1'b1);
    @(negedge clk);
  endtask
  initial begin
    void'($urandom(32'ha6193573));
    fork
      m.prime();
    join_none
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    wr(3, 'h35, 1, 10);
    wr(7, 'hfe, 18, 10);
    wr(0, 'h40, 0, 10);
    wr(2, 'h10, 1, 9);
    wp = 1'b1;
    wr(5, 'h77, 3, 10);
    m.start();
    m.put(8'ha3, ack);
    chk(ack, 1);
    m.stop();
    @(negedge clk);
    wp = 1'b0;
    wr($urandom % 8, $urandom % 256, 16, 10);
    tally_and_finish();
  end
endmodule
`default_nettype wire
